// ---- inc/dpbr_pkg.sv ----
// shared constants and types of the dual-port block memory with fifo and ecc
package dpbr_pkg;
   localparam int DPBR_DW        = 72;  // physical row width
   localparam int DPBR_ROW_AW    = 9;   // rows of the full memory, log2
   localparam int DPBR_AW        = 16;  // port address, cascade bit on top
   localparam int DPBR_CASC_BIT  = 15;  // block select bit in cascade mode
   localparam int DPBR_ROW_LD    = 6;   // log2 of data bits per row
   localparam int DPBR_BYTE_W    = 9;   // byte lane with its parity bit
   localparam int DPBR_BYTE_DW   = 8;   // data bits in a byte lane
   localparam int DPBR_LD_BYTE   = 3;   // width code of the 9-bit word
   localparam int DPBR_DATA_W    = 64;  // protected data bits
   localparam int DPBR_CHK_W     = 8;   // hamming check bits
   localparam int DPBR_FIFO_DW   = 36;
   localparam int DPBR_FIFO_DP   = 32;
   localparam int DPBR_FIFO_CW   = 6;   // fill level width, 0..32

   // code equals log2 of the data bits in one word
   typedef enum logic [2:0] {
      DPBR_W1  = 3'h0,
      DPBR_W2  = 3'h1,
      DPBR_W4  = 3'h2,
      DPBR_W9  = 3'h3,
      DPBR_W18 = 3'h4,
      DPBR_W36 = 3'h5,
      DPBR_W72 = 3'h6
   } dpbr_width_t;

   typedef enum logic [1:0] {
      DPBR_WRITE_FIRST = 2'h0,
      DPBR_READ_FIRST  = 2'h1,
      DPBR_NO_CHANGE   = 2'h2
   } dpbr_rmode_t;

   typedef struct packed {
      logic                 en;
      logic                 we;
      logic                 half;   // half select in split mode
      logic [DPBR_AW-1:0]   addr;
      logic [DPBR_DW-1:0]   wdata;
   } dpbr_req_t;

   typedef struct packed {
      dpbr_width_t width;
      dpbr_rmode_t rmode;
      logic        outreg;
   } dpbr_cfg_t;

   typedef struct packed {
      logic full;
      logic empty;
      logic afull;
      logic aempty;
   } dpbr_fifo_flags_t;
endpackage : dpbr_pkg

// ---- rtl/dpbr_fifo.sv ----
// fifo controller over a two-port array, standard or fall-through read
`timescale 1ns/1ps
module dpbr_fifo #(
   parameter int DW    = 36,
   parameter int DEPTH = 32
) (
   input  wire logic                     i_sys_clk,    // system clock
   input  wire logic                     i_reset_n,    // async reset, active low
   input  wire logic                     i_fwft,       // first-word fall-through
   input  wire logic [$clog2(DEPTH):0]   i_afull_thr,  // almost-full level
   input  wire logic [$clog2(DEPTH):0]   i_aempty_thr, // almost-empty level
   input  wire logic                     i_wr_valid,   // write request
   output logic                          o_wr_ready,   // room for a word
   input  wire logic [DW-1:0]            i_wr_data,    // write word
   output logic                          o_rd_valid,   // read word valid
   input  wire logic                     i_rd_ready,   // read request / accept
   output logic [DW-1:0]                 o_rd_data,    // read word
   output dpbr_pkg::dpbr_fifo_flags_t    o_flags       // status flags
);
   import dpbr_pkg::*;
   localparam int AW = $clog2(DEPTH);
   localparam int CW = AW + 1;

   logic [AW-1:0]       wptr_r, wptr_nxt, rptr_r, rptr_nxt;
   logic [CW-1:0]       mcnt_r, mcnt_nxt, total;
   logic                pend_r, pend_nxt, head_v_r, head_v_nxt, out_v_r, out_v_nxt;
   logic [DW-1:0]       head_r, head_nxt, dout_r, dout_nxt;
   logic                push, pop, issue;
   logic [1:0][DW-1:0]  m_rdata;

   always_comb begin
      total          = mcnt_r + CW'(pend_r) + CW'(head_v_r);
      o_flags.full   = total == CW'(DEPTH);
      o_flags.empty  = !head_v_r;
      o_flags.afull  = total >= i_afull_thr;
      o_flags.aempty = total <= i_aempty_thr;
      o_wr_ready     = !o_flags.full;
      push           = i_wr_valid && o_wr_ready;
      pop            = head_v_r && i_rd_ready;
      issue          = (mcnt_r != '0) && !pend_r && (!head_v_r || pop);
      wptr_nxt       = push ? wptr_r + 1'b1 : wptr_r;
      rptr_nxt       = issue ? rptr_r + 1'b1 : rptr_r;
      mcnt_nxt       = mcnt_r + CW'(push) - CW'(issue);
      pend_nxt       = issue;
      head_nxt       = pend_r ? m_rdata[1] : head_r;
      head_v_nxt     = pend_r || (head_v_r && !pop);
      out_v_nxt      = pop && !i_fwft;
      dout_nxt       = (pop && !i_fwft) ? head_r : dout_r;
      o_rd_valid     = i_fwft ? head_v_r : out_v_r;
      o_rd_data      = i_fwft ? head_r : dout_r;
   end

   always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         wptr_r   <= '0;
         rptr_r   <= '0;
         mcnt_r   <= '0;
         pend_r   <= 1'b0;
         head_v_r <= 1'b0;
         out_v_r  <= 1'b0;
         head_r   <= '0;
         dout_r   <= '0;
      end else begin
         wptr_r   <= wptr_nxt;
         rptr_r   <= rptr_nxt;
         mcnt_r   <= mcnt_nxt;
         pend_r   <= pend_nxt;
         head_v_r <= head_v_nxt;
         out_v_r  <= out_v_nxt;
         head_r   <= head_nxt;
         dout_r   <= dout_nxt;
      end
   end

   dpbr_mem #(
      .AW (AW),
      .DW (DW)
   ) u_store (
      .i_sys_clk (i_sys_clk),
      .i_reset_n (i_reset_n),
      .i_en      ({issue, push}),
      .i_we      (2'h1),
      .i_addr    ({rptr_r, wptr_r}),
      .i_mask    ({{DW{1'b0}}, {DW{1'b1}}}),
      .i_wdata   ({{DW{1'b0}}, i_wr_data}),
      .i_hold    (2'h0),
      .i_wfirst  (2'h0),
      .o_rdata   (m_rdata)
   );
endmodule : dpbr_fifo

// ---- rtl/dpbr_mem.sv ----
// two-port storage array with masked writes and registered read data
`timescale 1ns/1ps
module dpbr_mem #(
   parameter int AW = 9,
   parameter int DW = 72
) (
   input  wire logic                 i_sys_clk,  // system clock
   input  wire logic                 i_reset_n,  // async reset, active low
   input  wire logic [1:0]           i_en,       // access per port
   input  wire logic [1:0]           i_we,       // write per port
   input  wire logic [1:0][AW-1:0]   i_addr,     // row per port
   input  wire logic [1:0][DW-1:0]   i_mask,     // bit write mask
   input  wire logic [1:0][DW-1:0]   i_wdata,    // write row
   input  wire logic [1:0]           i_hold,     // keep output on write
   input  wire logic [1:0]           i_wfirst,   // new word on write
   output logic      [1:0][DW-1:0]   o_rdata     // registered read row
);
   logic [DW-1:0]          mem_r [2**AW];
   logic [1:0][DW-1:0]     rdata_nxt;

   // both ports write bitwise so disjoint lanes of one row both land
   always_ff @(posedge i_sys_clk) begin
      for (int p = 0; p < 2; p++) begin
         for (int b = 0; b < DW; b++) begin
            if (i_en[p] && i_we[p] && i_mask[p][b]) begin
               mem_r[i_addr[p]][b] <= i_wdata[p][b];
            end
         end
      end
   end

   always_comb begin
      for (int p = 0; p < 2; p++) begin
         rdata_nxt[p] = o_rdata[p];
         if (i_en[p]) begin
            if (i_we[p] && i_wfirst[p]) begin
               rdata_nxt[p] = (mem_r[i_addr[p]] & ~i_mask[p]) | (i_wdata[p] & i_mask[p]);
            end else if (!(i_we[p] && i_hold[p])) begin
               rdata_nxt[p] = mem_r[i_addr[p]];
            end
         end
      end
   end

   always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         o_rdata <= '0;
      end else begin
         o_rdata <= rdata_nxt;
      end
   end
endmodule : dpbr_mem

// ---- rtl/dpbr_top.sv ----
// dual-port block memory with aspect ratios, ecc and a fifo controller
`timescale 1ns/1ps
// Functional notes
// - two independent ports share only array
// - all accesses happen on clock edges
// - address and read data hold
// - optional output register adds one cycle
// - write read-out: old, new or unchanged
// - seven depth-by-width aspect ratios per port
// - ports choose widths independently
// - split into two half-size memories
// - widest words only in simple two-port
// - simple mode: one side fixed wide
// - two blocks cascade as 64K by 1
// - 64-bit words get eight hamming bits
// - encoder and decoder usable standalone
// - fifo advances its own addresses
// - fifo full, empty, almost flags
// - almost thresholds freely programmable
// - fifo sides share one width
// - fall-through shows first word early
// - after first read, standard behaviour (here fall-through continues)
module dpbr_top (
   input  wire logic                            i_sys_clk,              // system clock
   input  wire logic                            i_reset_n,              // async reset, low
   input  dpbr_pkg::dpbr_req_t [1:0]            i_req,                  // port requests
   input  dpbr_pkg::dpbr_cfg_t [1:0]            i_cfg,                  // port settings
   output logic [1:0][dpbr_pkg::DPBR_DW-1:0]    o_rdata,                // port read data
   input  wire logic                            i_simple_two_port_mode, // a writes, b reads
   input  wire logic                            i_split,                // two half memories
   input  wire logic                            i_ecc_en,               // ecc on 72-bit words
   output logic [1:0]                           o_ecc_sbit,             // corrected, pulse
   output logic [1:0]                           o_ecc_dbit,             // double error, pulse
   input  wire logic                            i_casc_en,              // cascade as 64K by 1
   input  wire logic                            i_casc_upper,           // this is upper block
   input  wire logic [1:0]                      i_casc_rdata,           // bit from neighbour
   output logic [1:0]                           o_casc_rdata,           // bit to neighbour
   input  wire logic [dpbr_pkg::DPBR_DATA_W-1:0] i_xenc_data,           // external encode in
   output logic [dpbr_pkg::DPBR_CHK_W-1:0]      o_xenc_check,           // check bits out
   input  wire logic [dpbr_pkg::DPBR_DW-1:0]    i_xdec_word,            // external decode in
   output logic [dpbr_pkg::DPBR_DATA_W-1:0]     o_xdec_data,            // corrected data
   output logic                                 o_xdec_sbit,            // single corrected
   output logic                                 o_xdec_dbit,            // double detected
   input  wire logic                            i_fifo_fwft,            // fall-through mode
   input  wire logic [dpbr_pkg::DPBR_FIFO_CW-1:0] i_fifo_afull_thr,     // almost-full level
   input  wire logic [dpbr_pkg::DPBR_FIFO_CW-1:0] i_fifo_aempty_thr,    // almost-empty level
   input  wire logic                            i_fifo_wr_valid,        // fifo write request
   output logic                                 o_fifo_wr_ready,        // fifo has room
   input  wire logic [dpbr_pkg::DPBR_FIFO_DW-1:0] i_fifo_wr_data,       // fifo write word
   output logic                                 o_fifo_rd_valid,        // fifo read valid
   input  wire logic                            i_fifo_rd_ready,        // fifo read request
   output logic [dpbr_pkg::DPBR_FIFO_DW-1:0]    o_fifo_rd_data,         // fifo read word
   output dpbr_pkg::dpbr_fifo_flags_t           o_fifo_flags            // fifo flags
);
   import dpbr_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // lane mapping: user bit index for a physical row bit, or -1
   function automatic int slot(input logic [2:0] ld, input logic [5:0] lane, input int b);
      int byt;
      int bi;
      int j;
      int sh;
      byt  = b / DPBR_BYTE_W;
      bi   = b % DPBR_BYTE_W;
      j    = byt * DPBR_BYTE_DW + bi;
      sh   = int'(ld) - DPBR_LD_BYTE;
      slot = -1;
      if (bi == DPBR_BYTE_DW) begin
         if (sh >= 0 && (byt >> sh) == int'(lane)) begin
            slot = (1 << ld) + (byt & ((1 << sh) - 1));
         end
      end else if ((j >> ld) == int'(lane)) begin
         slot = j & ((1 << ld) - 1);
      end
   endfunction : slot

   ////////////////////////////////////////////////////////////////////////////
   // hamming secded over codeword positions 1..71, overall parity on top
   function automatic logic [6:0] ecc_syn(input logic [DPBR_DW-1:0] c);
      ecc_syn = '0;
      for (int p = 1; p < DPBR_DW; p++) begin
         if (c[p]) begin
            ecc_syn = ecc_syn ^ 7'(p);
         end
      end
   endfunction : ecc_syn

   function automatic logic [DPBR_DW-1:0] ecc_spread(input logic [DPBR_DATA_W-1:0] d,
                                                     input logic [6:0] chk);
      int n;
      int k;
      n          = 0;
      k          = 0;
      ecc_spread = '0;
      for (int p = 1; p < DPBR_DW; p++) begin
         if ((p & (p - 1)) != 0) begin
            ecc_spread[p] = d[n];
            n++;
         end else begin
            ecc_spread[p] = chk[k];
            k++;
         end
      end
   endfunction : ecc_spread

   function automatic logic [DPBR_DATA_W-1:0] ecc_gather(input logic [DPBR_DW-1:0] c);
      int n;
      n          = 0;
      ecc_gather = '0;
      for (int p = 1; p < DPBR_DW; p++) begin
         if ((p & (p - 1)) != 0) begin
            ecc_gather[n] = c[p];
            n++;
         end
      end
   endfunction : ecc_gather

   function automatic logic [DPBR_CHK_W-1:0] ecc_enc(input logic [DPBR_DATA_W-1:0] d);
      logic [6:0] s;
      s       = ecc_syn(ecc_spread(d, '0));
      ecc_enc = {(^d) ^ (^s), s};
   endfunction : ecc_enc

   // result is {double, single, corrected data}
   function automatic logic [DPBR_DATA_W+1:0] ecc_dec(input logic [DPBR_DW-1:0] w);
      logic [DPBR_DW-1:0] c;
      logic [6:0]         s;
      logic               ov;
      logic               sb;
      c  = ecc_spread(w[DPBR_DATA_W-1:0], w[DPBR_DW-2:DPBR_DATA_W]);
      s  = ecc_syn(c);
      ov = ^w;
      sb = ov && (int'(s) < DPBR_DW);
      if (sb && s != '0) begin
         c[s] = ~c[s];
      end
      ecc_dec = {(s != '0 && !ov) || (ov && !sb), sb, ecc_gather(c)};
   endfunction : ecc_dec

   ////////////////////////////////////////////////////////////////////////////
   // port front end and read pipeline
   dpbr_width_t [1:0]              ew;
   dpbr_width_t                    mx;
   logic [1:0]                     own;
   logic [1:0]                     we;
   logic [1:0]                     ecc;
   logic [1:0][5:0]                lane;
   logic [1:0]                     m_en;
   logic [1:0]                     m_hold;
   logic [1:0]                     m_wfirst;
   logic [1:0][DPBR_ROW_AW-1:0]    m_addr;
   logic [1:0][DPBR_DW-1:0]        m_mask;
   logic [1:0][DPBR_DW-1:0]        m_wdata;
   logic [1:0][DPBR_DW-1:0]        m_rdata;
   logic [1:0][DPBR_DW-1:0]        ext;
   logic [1:0]                     s1_upd_r, s1_upd_nxt;
   logic [1:0]                     s1_ecc_r, s1_ecc_nxt;
   logic [1:0]                     s1_own_r, s1_own_nxt;
   dpbr_width_t [1:0]              s1_ld_r, s1_ld_nxt;
   logic [1:0][5:0]                s1_lane_r, s1_lane_nxt;
   logic [1:0][DPBR_DW-1:0]        dout_r, dout_nxt;
   logic [1:0][DPBR_DW-1:0]        dout2_r, dout2_nxt;
   logic [1:0]                     sbit_r, sbit_nxt;
   logic [1:0]                     dbit_r, dbit_nxt;

   always_comb begin
      logic [DPBR_CASC_BIT-1:0] word;
      logic [DPBR_DW-1:0]       w;
      logic [DPBR_DATA_W+1:0]   dec;
      int                       k;
      word = '0;
      w    = '0;
      dec  = '0;
      k    = 0;
      // widest words only in simple mode
      if (i_simple_two_port_mode) begin
         mx = i_split ? DPBR_W36 : DPBR_W72;
      end else begin
         mx = i_split ? DPBR_W18 : DPBR_W36;
      end
      for (int p = 0; p < 2; p++) begin
         ew[p] = (i_cfg[p].width > mx) ? mx : i_cfg[p].width;
         if (i_casc_en) begin
            ew[p] = DPBR_W1;
         end
      end
      if (i_simple_two_port_mode && !i_casc_en && ew[1] < DPBR_W36) begin
         ew[0] = mx;
      end
      for (int p = 0; p < 2; p++) begin
         own[p]     = !i_casc_en || (i_req[p].addr[DPBR_CASC_BIT] == i_casc_upper);
         // word address to row and lane
         word       = i_req[p].addr[DPBR_CASC_BIT-1:0] >> (DPBR_ROW_LD - int'(ew[p]));
         lane[p]    = 6'(i_req[p].addr & ((16'h1 << (DPBR_ROW_LD - int'(ew[p]))) - 16'h1));
         m_addr[p]  = i_split ? {i_req[p].half, word[DPBR_ROW_AW-2:0]}
                              : word[DPBR_ROW_AW-1:0];
         we[p]      = i_req[p].we && own[p] && !(i_simple_two_port_mode && p == 1);
         // check bits stored with 64-bit words
         ecc[p]     = i_ecc_en && ew[p] == DPBR_W72;
         w          = i_req[p].wdata;
         if (ecc[p]) begin
            w[DPBR_DW-1:DPBR_DATA_W] = ecc_enc(w[DPBR_DATA_W-1:0]);
         end
         m_mask[p]  = '0;
         m_wdata[p] = '0;
         for (int b = 0; b < DPBR_DW; b++) begin
            k = slot(ew[p], lane[p], b);
            if (k >= 0) begin
               m_mask[p][b]  = 1'b1;
               m_wdata[p][b] = w[k];
            end
         end
         // requests go straight into clocked array
         m_en[p]     = i_req[p].en;
         m_hold[p]   = i_cfg[p].rmode == DPBR_NO_CHANGE;
         m_wfirst[p] = i_cfg[p].rmode == DPBR_WRITE_FIRST;
         // captured access held until next one
         s1_upd_nxt[p]  = 1'b0;
         s1_ecc_nxt[p]  = s1_ecc_r[p];
         s1_own_nxt[p]  = s1_own_r[p];
         s1_ld_nxt[p]   = s1_ld_r[p];
         s1_lane_nxt[p] = s1_lane_r[p];
         if (i_req[p].en) begin
            s1_upd_nxt[p]  = !(we[p] && m_hold[p]) && !(i_simple_two_port_mode && p == 0);
            s1_ecc_nxt[p]  = ecc[p];
            s1_own_nxt[p]  = own[p];
            s1_ld_nxt[p]   = ew[p];
            s1_lane_nxt[p] = lane[p];
         end
         ext[p] = '0;
         for (int b = 0; b < DPBR_DW; b++) begin
            k = slot(s1_ld_r[p], s1_lane_r[p], b);
            if (k >= 0) begin
               ext[p][k] = m_rdata[p][b];
            end
         end
         o_casc_rdata[p] = ext[p][0];
         dout_nxt[p]     = dout_r[p];
         sbit_nxt[p]     = 1'b0;
         dbit_nxt[p]     = 1'b0;
         if (s1_upd_r[p]) begin
            if (!s1_own_r[p]) begin
               dout_nxt[p] = {{(DPBR_DW-1){1'b0}}, i_casc_rdata[p]};
            end else if (s1_ecc_r[p]) begin
               dec         = ecc_dec(ext[p]);
               dout_nxt[p] = {ext[p][DPBR_DW-1:DPBR_DATA_W], dec[DPBR_DATA_W-1:0]};
               sbit_nxt[p] = dec[DPBR_DATA_W];
               dbit_nxt[p] = dec[DPBR_DATA_W+1];
            end else begin
               dout_nxt[p] = ext[p];
            end
         end
         dout2_nxt[p] = dout_r[p];
         o_rdata[p]   = i_cfg[p].outreg ? dout2_r[p] : dout_r[p];
      end
      o_ecc_sbit = sbit_r;
      o_ecc_dbit = dbit_r;
   end

   always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         s1_upd_r  <= '0;
         s1_ecc_r  <= '0;
         s1_own_r  <= '0;
         s1_ld_r   <= {DPBR_W1, DPBR_W1};
         s1_lane_r <= '0;
         dout_r    <= '0;
         dout2_r   <= '0;
         sbit_r    <= '0;
         dbit_r    <= '0;
      end else begin
         s1_upd_r  <= s1_upd_nxt;
         s1_ecc_r  <= s1_ecc_nxt;
         s1_own_r  <= s1_own_nxt;
         s1_ld_r   <= s1_ld_nxt;
         s1_lane_r <= s1_lane_nxt;
         dout_r    <= dout_nxt;
         dout2_r   <= dout2_nxt;
         sbit_r    <= sbit_nxt;
         dbit_r    <= dbit_nxt;
      end
   end

   dpbr_mem #(
      .AW (DPBR_ROW_AW),
      .DW (DPBR_DW)
   ) u_array (
      .i_sys_clk (i_sys_clk),
      .i_reset_n (i_reset_n),
      .i_en      (m_en),
      .i_we      (we),
      .i_addr    (m_addr),
      .i_mask    (m_mask),
      .i_wdata   (m_wdata),
      .i_hold    (m_hold),
      .i_wfirst  (m_wfirst),
      .o_rdata   (m_rdata)
   );

   ////////////////////////////////////////////////////////////////////////////
   // standalone encoder and decoder
   logic [DPBR_CHK_W-1:0]    xchk_r, xchk_nxt;
   logic [DPBR_DATA_W+1:0]   xdec_r, xdec_nxt;

   always_comb begin
      xchk_nxt     = ecc_enc(i_xenc_data);
      xdec_nxt     = ecc_dec(i_xdec_word);
      o_xenc_check = xchk_r;
      o_xdec_data  = xdec_r[DPBR_DATA_W-1:0];
      o_xdec_sbit  = xdec_r[DPBR_DATA_W];
      o_xdec_dbit  = xdec_r[DPBR_DATA_W+1];
   end

   always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         xchk_r <= '0;
         xdec_r <= '0;
      end else begin
         xchk_r <= xchk_nxt;
         xdec_r <= xdec_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // fifo controller
   // fifo on the common clock
   dpbr_fifo #(
      .DW    (DPBR_FIFO_DW),
      .DEPTH (DPBR_FIFO_DP)
   ) u_fifo (
      .i_sys_clk    (i_sys_clk),
      .i_reset_n    (i_reset_n),
      .i_fwft       (i_fifo_fwft),
      .i_afull_thr  (i_fifo_afull_thr),
      .i_aempty_thr (i_fifo_aempty_thr),
      .i_wr_valid   (i_fifo_wr_valid),
      .o_wr_ready   (o_fifo_wr_ready),
      .i_wr_data    (i_fifo_wr_data),
      .o_rd_valid   (o_fifo_rd_valid),
      .i_rd_ready   (i_fifo_rd_ready),
      .o_rd_data    (o_fifo_rd_data),
      .o_flags      (o_fifo_flags)
   );
endmodule : dpbr_top

// ---- tb/dpbr_checker.sv ----
// port assertions for the block memory top
`timescale 1ns/1ps
module dpbr_checker (
   input wire logic                              i_sys_clk,       // clock
   input wire logic                              i_reset_n,       // reset
   input dpbr_pkg::dpbr_req_t [1:0]              i_req,           // requests
   input wire logic [1:0][dpbr_pkg::DPBR_DW-1:0] o_rdata,         // read data
   input wire logic                              i_fifo_fwft,     // mode
   input wire logic                              i_fifo_wr_valid, // write
   input wire logic                              o_fifo_wr_ready, // room
   input wire logic                              o_fifo_rd_valid, // valid
   input wire logic                              i_fifo_rd_ready, // read
   input dpbr_pkg::dpbr_fifo_flags_t             o_fifo_flags,    // flags
   input wire logic [dpbr_pkg::DPBR_DATA_W-1:0]  i_xenc_data,     // encode in
   input wire logic [dpbr_pkg::DPBR_CHK_W-1:0]   o_xenc_check     // check out
);
   import dpbr_pkg::*;
   default clocking @(posedge i_sys_clk); endclocking
   default disable iff (!i_reset_n);
   sequence s_wr_empty;
      o_fifo_flags.empty && i_fifo_wr_valid && o_fifo_wr_ready;
   endsequence
   sequence s_std_read;
      !i_fifo_fwft && i_fifo_rd_ready && !o_fifo_flags.empty;
   endsequence
   a_ready_not_full: assert property (o_fifo_wr_ready == !o_fifo_flags.full)
      else $error("write ready disagrees with full");
   a_fwft_valid: assert property (i_fifo_fwft |-> o_fifo_rd_valid == !o_fifo_flags.empty)
      else $error("fall-through valid disagrees with empty");
   a_first_word: assert property (s_wr_empty |-> ##[1:3] !o_fifo_flags.empty)
      else $error("first word late");
   a_std_read: assert property (s_std_read |=> o_fifo_rd_valid)
      else $error("read gave no valid");
   a_std_pulse: assert property (!i_fifo_fwft && o_fifo_rd_valid |=> !o_fifo_rd_valid)
      else $error("valid longer than one cycle");
   a_full_hold: assert property (o_fifo_flags.full && !i_fifo_rd_ready |=> o_fifo_flags.full)
      else $error("full dropped without read");
   a_xenc_zero: assert property (i_xenc_data == '0 |=> o_xenc_check == '0)
      else $error("check bits of zero word");
   a_rdata_hold: assert property (!i_req[0].en [*3] |=> $stable(o_rdata[0]))
      else $error("read data moved without access");
endmodule : dpbr_checker
bind dpbr_top dpbr_checker chk_u (.i_sys_clk, .i_reset_n, .i_req, .o_rdata, .i_fifo_fwft,
   .i_fifo_wr_valid, .o_fifo_wr_ready, .o_fifo_rd_valid, .i_fifo_rd_ready, .o_fifo_flags,
   .i_xenc_data, .o_xenc_check);

// ---- tb/dpbr_reader.sv ----
// slow fifo reader standing in for user logic
`timescale 1ns/1ps
module dpbr_reader (
   input  wire logic                              i_sys_clk,  // clock
   input  wire logic                              i_reset_n,  // reset
   input  wire logic                              i_go,       // drain
   input  wire logic                              i_fwft,     // mode
   input  wire logic                              i_rd_valid, // valid
   input  wire logic [dpbr_pkg::DPBR_FIFO_DW-1:0] i_rd_data,  // word
   input  wire logic                              i_empty,    // empty
   output logic                                   o_rd_ready  // read
);
   import dpbr_pkg::*;
   logic [DPBR_FIFO_DW-1:0] got [$];
   logic                    stall_r;
   always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
      if (!i_reset_n) stall_r <= 1'b0;
      else stall_r <= ~stall_r;
   end
   assign o_rd_ready = i_go && stall_r && !i_empty;
   always @(posedge i_sys_clk) begin
      if (i_fwft ? (i_rd_valid && o_rd_ready) : i_rd_valid) got.push_back(i_rd_data);
   end
endmodule : dpbr_reader

// ---- tb/tb_dpbr_top.sv ----
// self-checking bench for the block memory top
`timescale 1ns/1ps
module tb_dpbr_top;
   import dpbr_pkg::*;
   logic clk = 0, rst_n = 0, fwft = 0, wv = 0, go = 0, wr_rdy, rv, rr, xs, xdd;
   int miscompares = 0, n_compared = 0, cyc = 0;
   dpbr_req_t [1:0] req = '0;
   dpbr_cfg_t [1:0] cfg = {2{dpbr_cfg_t'{DPBR_W36, DPBR_WRITE_FIRST, 1'b0}}};
   logic [1:0][DPBR_DW-1:0] rdata;
   logic [DPBR_FIFO_DW-1:0] wd = '0, rd;
   logic [DPBR_DATA_W-1:0]  xe = 64'h0123_4567_89ab_cdef, xd;
   logic [DPBR_DW-1:0]      xw = '0;
   logic [7:0]              xc;
   logic                    ecc = 0, spl = 0, cup = 0;
   dpbr_fifo_flags_t        flags;
   dpbr_top dut_u (.i_sys_clk(clk), .i_reset_n(rst_n), .i_req(req), .i_cfg(cfg),
      .o_rdata(rdata), .i_simple_two_port_mode(1'b0), .i_split(spl), .i_ecc_en(ecc),
      .o_ecc_sbit(), .o_ecc_dbit(), .i_casc_en(1'b0), .i_casc_upper(cup),
      .i_casc_rdata(2'h0), .o_casc_rdata(), .i_xenc_data(xe), .o_xenc_check(xc),
      .i_xdec_word(xw), .o_xdec_data(xd), .o_xdec_sbit(xs), .o_xdec_dbit(xdd),
      .i_fifo_fwft(fwft), .i_fifo_afull_thr(6'h20), .i_fifo_aempty_thr(6'h00),
      .i_fifo_wr_valid(wv), .o_fifo_wr_ready(wr_rdy), .i_fifo_wr_data(wd),
      .o_fifo_rd_valid(rv), .i_fifo_rd_ready(rr), .o_fifo_rd_data(rd), .o_fifo_flags(flags));
   dpbr_reader rdr_u (.i_sys_clk(clk), .i_reset_n(rst_n), .i_go(go), .i_fwft(fwft),
      .i_rd_valid(rv), .i_rd_data(rd), .i_empty(flags.empty), .o_rd_ready(rr));
   initial forever #5 clk = ~clk;
   task automatic check(input logic ok, input string msg);
      n_compared++;
      if (ok !== 1'b1) begin
         miscompares++;
         $display("unexpected at %0t: %s", $time, msg);
      end
   endtask : check
   task automatic stop_test;
      $display("compared %0d miscompares %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : stop_test
   task automatic do_reset(input logic f);
      fwft <= f;
      rst_n <= 1'b0;
      repeat (12) @(posedge clk);
      rst_n <= 1'b1;
   endtask : do_reset
   task automatic t_mem;
      req[0] <= '{1'b1, 1'b1, 1'b0, 16'h0003, 72'h5_a5a5_a5a5};
      @(posedge clk);
      req[0].en <= 1'b0;
      req[1] <= '{1'b1, 1'b0, 1'b0, 16'h0003, 72'h0};
      @(posedge clk);
      req[1].en <= 1'b0;
      @(posedge clk);
      #1 check(rdata[1][35:0] === 36'h5_a5a5_a5a5, "port b read");
      check(rdata[0][35:0] === 36'h5_a5a5_a5a5, "write-first output");
   endtask : t_mem
   task automatic t_codec;
      @(posedge clk);
      xw <= {xc, xe ^ 64'h10};
      @(posedge clk);
      xw <= {xc, xe ^ 64'h30};
      #1 check(xd === xe && xs === 1'b1 && xdd === 1'b0, "single bit fix");
      @(posedge clk);
      #1 check(xdd === 1'b1, "double bit flag");
   endtask : t_codec
   task automatic t_fifo;
      int i;
      for (i = 0; i < 33; i++) begin
         @(posedge clk);
         wv <= 1'b1;
         wd <= 36'(i) + 36'h100;
      end
      @(posedge clk);
      wv <= 1'b0;
      #1 check(flags === 4'b1010, "full flags");
      go <= 1'b1;
      for (i = 0; i < 300 && rdr_u.got.size() < 32; i++) @(posedge clk);
      #1 check(flags === 4'b0101 && rdr_u.got.size() == 32, "drained");
      for (i = 0; i < 32; i++) check(rdr_u.got[i] === 36'(i) + 36'h100, "order");
      @(posedge clk);
      go <= 1'b0;
   endtask : t_fifo
   task automatic t_fwft;
      int i;
      do_reset(1'b1);
      wv <= 1'b1;
      wd <= 36'h9_abcd_1234;
      @(posedge clk);
      wv <= 1'b0;
      for (i = 0; i < 5 && rv !== 1'b1; i++) @(posedge clk);
      #1 check(rv === 1'b1 && rd === 36'h9_abcd_1234, "head before read");
      go <= 1'b1;
      for (i = 0; i < 20 && rdr_u.got.size() < 33; i++) @(posedge clk);
      #1 check(rdr_u.got[32] === 36'h9_abcd_1234 && flags.empty === 1'b1, "pop");
   endtask : t_fwft
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         miscompares++;
         stop_test();
      end
   end
   initial begin
      do_reset(1'b0);
      t_mem();
      t_codec();
      t_fifo();
      t_fwft();
      stop_test();
   end
endmodule : tb_dpbr_top
